// *** port_cfg_pkg.sv ***
package port_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  // register word addresses (printed offsets are not all multiples of four)
  localparam logic [ADDR_W-1:0] IDX_PORT2_PULLUP = 8'hE4;
  localparam logic [ADDR_W-1:0] IDX_PORT3_IRQ = 8'hEF;
  localparam logic [ADDR_W-1:0] IDX_PORT3_MODE = 8'hF0;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 8'hF8;
  localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR = 8'hF9;
  localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE = 8'hFA;
  localparam logic [ADDR_W-1:0] IDX_PIN_STATE = 8'hFB;
  localparam logic [REG_W-1:0] PULLUP_RESET = 8'h00;
  localparam logic [REG_W-1:0] MODE_RESET = 8'h00;
  localparam logic [REG_W-1:0] IRQ_RESET = 8'h00;
  localparam logic [REG_W-1:0] PULLUP_IMPL_MASK = 8'h7F;
  localparam int P2_PINS = 7;
  localparam int P3_PINS = 4;
  localparam logic [1:0] MODE_IN = 2'h0;
  localparam logic [1:0] MODE_IN_PU = 2'h1;
  localparam logic [1:0] MODE_OUT = 2'h2;
  localparam logic [1:0] MODE_ANALOG = 2'h3;
  // pin i of port 3: enable at bit 2i+1, pending at bit 2i
  localparam int IRQ_EN_OFS = 1;
  localparam int IRQ_PND_OFS = 0;
  // pins 0 and 1 have an analog alternative
  localparam logic [P3_PINS-1:0] ANALOG_CAPABLE = 4'h3;
  // bus data outside a register read and with every error answer
  localparam logic [DATA_W-1:0] ACK_ERR_DATA = 32'h0000_0000;
endpackage : port_cfg_pkg

// *** fall_detect.sv ***
`timescale 1ns/1ps
module fall_detect (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [port_cfg_pkg::P3_PINS-1:0] pin_level,
  input wire logic [port_cfg_pkg::P3_PINS-1:0] arm,
  output logic [port_cfg_pkg::P3_PINS-1:0] fall
);
  import port_cfg_pkg::*;
  logic [P3_PINS-1:0] last_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      last_reg <= {P3_PINS{1'b1}};
    end else if (ce) begin
      last_reg <= pin_level;
    end
  end
  // only falling transitions on armed pins count
  assign fall = last_reg & ~pin_level & arm & {P3_PINS{ce}};
endmodule : fall_detect

// *** port_cfg.sv ***
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
// Overview of operation
// - Port 2 pins 6..0 have their pull-up on when the control bit is 0 and off when it is 1.
// - Port 3 pins 3 and 2 use modes 00 input, 01 input with pull-up, 1x push-pull output.
// - Port 3 pins 1 and 0 use modes 00 input, 01 input with pull-up, 10 output, 11 analog.
// - A port 3 pin in an input mode is a falling-edge interrupt source, falling edges only.
// - In the interrupt register the odd bit of each pair enables a line, the even bit pends.
// - A pending bit reads 1 while an interrupt is pending and 0 otherwise.
// - Writing 0 to a pending bit clears it and writing 1 leaves it unchanged.
// - Pin 3 drives line seven, pin 2 line six, pin 1 line five and pin 0 line four.
// - Reset clears all port 3 mode, enable and pending bits to 0.
module port_cfg (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [port_cfg_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [port_cfg_pkg::DATA_W-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [port_cfg_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [port_cfg_pkg::P3_PINS-1:0] port3_pin_in,
  input wire logic [port_cfg_pkg::P3_PINS-1:0] port3_pin_out_data,
  output logic [port_cfg_pkg::P3_PINS-1:0] port3_pin_out,
  output logic [port_cfg_pkg::P3_PINS-1:0] port3_pin_oe,
  output logic [port_cfg_pkg::P3_PINS-1:0] port3_pullup_en,
  output logic [port_cfg_pkg::P3_PINS-1:0] port3_analog_sel,
  output logic [port_cfg_pkg::P2_PINS-1:0] port2_pullup_en,
  output logic [port_cfg_pkg::P3_PINS-1:0] ext_irq_line,
  output logic irq
);
  import port_cfg_pkg::*;

  logic [REG_W-1:0] port2_pullup_control_reg;
  logic [REG_W-1:0] port3_pin_mode_reg;
  logic [REG_W-1:0] port3_irq_enable_pending_reg;
  logic [P3_PINS-1:0] irq_status_reg;
  logic [P3_PINS-1:0] irq_enable_reg;
  logic [P3_PINS-1:0] fall;
  logic [P3_PINS-1:0] input_mode;
  logic [P3_PINS-1:0] pend_vec;
  logic [P3_PINS-1:0] en_vec;
  logic [P3_PINS-1:0] pend_next;
  logic wr_lo;
  logic req;
  logic known_adr;

  function automatic logic [1:0] pin_mode(input logic [REG_W-1:0] m, input int i);
    pin_mode = m[2*i +: 2];
  endfunction : pin_mode

  // only the low byte carries register data
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wr_lo = req & wb_we_i & wb_sel_i[0] & ce;
  always_comb begin
    case (wb_adr_i)
      IDX_PORT2_PULLUP, IDX_PORT3_IRQ, IDX_PORT3_MODE, IDX_IRQ_STATUS,
      IDX_IRQ_CLEAR, IDX_IRQ_ENABLE, IDX_PIN_STATE: known_adr = 1'b1;
      default: known_adr = 1'b0;
    endcase
  end

  always_comb begin
    for (int i = 0; i < P3_PINS; i++) begin
      input_mode[i] = pin_mode(port3_pin_mode_reg, i) inside {MODE_IN, MODE_IN_PU};
      pend_vec[i] = port3_irq_enable_pending_reg[2*i + IRQ_PND_OFS];
      en_vec[i] = port3_irq_enable_pending_reg[2*i + IRQ_EN_OFS];
    end
  end

  fall_detect u_fall (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .pin_level(port3_pin_in),
    .arm(input_mode),
    .fall(fall)
  );

  // set beats a simultaneous software clear
  always_comb begin
    pend_next = pend_vec;
    if (wr_lo && wb_adr_i == IDX_PORT3_IRQ) begin
      for (int i = 0; i < P3_PINS; i++) begin
        if (!wb_dat_i[2*i + IRQ_PND_OFS]) begin
          pend_next[i] = 1'b0;
        end
      end
    end
    pend_next = pend_next | fall;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port2_pullup_control_reg <= PULLUP_RESET;
    end else if (wr_lo && wb_adr_i == IDX_PORT2_PULLUP) begin
      port2_pullup_control_reg <= wb_dat_i[REG_W-1:0] & PULLUP_IMPL_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port3_pin_mode_reg <= MODE_RESET;
    end else if (wr_lo && wb_adr_i == IDX_PORT3_MODE) begin
      port3_pin_mode_reg <= wb_dat_i[REG_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port3_irq_enable_pending_reg <= IRQ_RESET;
    end else if (ce) begin
      for (int i = 0; i < P3_PINS; i++) begin
        port3_irq_enable_pending_reg[2*i + IRQ_PND_OFS] <= pend_next[i];
        if (wr_lo && wb_adr_i == IDX_PORT3_IRQ) begin
          port3_irq_enable_pending_reg[2*i + IRQ_EN_OFS] <= wb_dat_i[2*i + IRQ_EN_OFS];
        end
      end
    end
  end

  // summary status: sticky, set by edges, cleared by writing 1 to clear register
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_status_reg <= '0;
    end else if (ce) begin
      if (wr_lo && wb_adr_i == IDX_IRQ_CLEAR) begin
        irq_status_reg <= (irq_status_reg & ~wb_dat_i[P3_PINS-1:0]) | fall;
      end else begin
        irq_status_reg <= irq_status_reg | fall;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_enable_reg <= '0;
    end else if (wr_lo && wb_adr_i == IDX_IRQ_ENABLE) begin
      irq_enable_reg <= wb_dat_i[P3_PINS-1:0];
    end
  end

  // pin drivers and per-line requests, all registered
  always_ff @(posedge clk) begin
    if (srst) begin
      port3_pin_out <= '0;
      port3_pin_oe <= '0;
      port3_pullup_en <= '0;
      port3_analog_sel <= '0;
      port2_pullup_en <= '0;
      ext_irq_line <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      for (int i = 0; i < P3_PINS; i++) begin
        port3_pin_oe[i] <= pin_mode(port3_pin_mode_reg, i) == MODE_OUT
          || (pin_mode(port3_pin_mode_reg, i) == MODE_ANALOG && !ANALOG_CAPABLE[i]);
        port3_pullup_en[i] <= pin_mode(port3_pin_mode_reg, i) == MODE_IN_PU;
        port3_analog_sel[i] <= pin_mode(port3_pin_mode_reg, i) == MODE_ANALOG
          && ANALOG_CAPABLE[i];
        // index i is line four plus i
        ext_irq_line[i] <= pend_vec[i] & en_vec[i];
      end
      port3_pin_out <= port3_pin_out_data;
      port2_pullup_en <= ~port2_pullup_control_reg[P2_PINS-1:0];
      irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // one wait-free answer per request, low for a cycle after
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= ACK_ERR_DATA;
    end else if (ce) begin
      wb_ack_o <= req & known_adr;
      wb_err_o <= req & ~known_adr;
      wb_dat_o <= ACK_ERR_DATA;
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          IDX_PORT2_PULLUP: wb_dat_o[REG_W-1:0] <= port2_pullup_control_reg;
          IDX_PORT3_IRQ: wb_dat_o[REG_W-1:0] <= port3_irq_enable_pending_reg;
          IDX_PORT3_MODE: wb_dat_o[REG_W-1:0] <= port3_pin_mode_reg;
          IDX_IRQ_STATUS: wb_dat_o[P3_PINS-1:0] <= irq_status_reg;
          IDX_IRQ_ENABLE: wb_dat_o[P3_PINS-1:0] <= irq_enable_reg;
          IDX_PIN_STATE: wb_dat_o[P3_PINS-1:0] <= port3_pin_in;
          default: wb_dat_o <= ACK_ERR_DATA;
        endcase
      end
    end
  end

  reset_clears_a: assert property (@(posedge clk) srst |=> port3_pin_mode_reg == MODE_RESET
    && port3_irq_enable_pending_reg == IRQ_RESET) else $error("reset left port 3 state");
  pullup_inv_a: assert property (@(posedge clk) disable iff (srst) ce
    |=> port2_pullup_en == ~$past(port2_pullup_control_reg[P2_PINS-1:0]))
    else $error("port 2 pull-up not inverse of control");
  out_mode_a: assert property (@(posedge clk) disable iff (srst)
    ce && port3_pin_mode_reg[7] |=> port3_pin_oe[3]) else $error("pin three not driven");
  analog_sel_a: assert property (@(posedge clk) disable iff (srst)
    ce && port3_pin_mode_reg[1:0] == MODE_ANALOG |=> port3_analog_sel[0] && !port3_pin_oe[0])
    else $error("pin zero analog select wrong");
  edge_sets_a: assert property (@(posedge clk) disable iff (srst)
    fall[3] |=> port3_irq_enable_pending_reg[6]) else $error("edge did not set line seven");
  no_rise_a: assert property (@(posedge clk) disable iff (srst)
    ce && !fall[0] && !port3_irq_enable_pending_reg[0] |=> !port3_irq_enable_pending_reg[0])
    else $error("pending set without falling edge");
  wr_zero_a: assert property (@(posedge clk) disable iff (srst)
    wr_lo && wb_adr_i == IDX_PORT3_IRQ && !wb_dat_i[2] && !fall[1]
    |=> !port3_irq_enable_pending_reg[2]) else $error("pending not cleared by 0");
  wr_one_a: assert property (@(posedge clk) disable iff (srst)
    wr_lo && wb_adr_i == IDX_PORT3_IRQ && wb_dat_i[4] && port3_irq_enable_pending_reg[4]
    |=> port3_irq_enable_pending_reg[4]) else $error("writing 1 changed pending");
  line_req_a: assert property (@(posedge clk) disable iff (srst)
    ce && port3_irq_enable_pending_reg[7:6] == 2'h3 |=> ext_irq_line[3])
    else $error("line seven request missing");
  read_pend_a: assert property (@(posedge clk) disable iff (srst)
    ce && req && !wb_we_i && wb_adr_i == IDX_PORT3_IRQ
    |=> wb_ack_o && wb_dat_o[0] == $past(port3_irq_enable_pending_reg[0]))
    else $error("pending read back wrong");

  // bus answer shape
  ack_pulse_a: assert property (@(posedge clk) disable iff (srst)
    ce && wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  err_pulse_a: assert property (@(posedge clk) disable iff (srst)
    ce && wb_err_o |=> !wb_err_o)
    else $error("err held longer than one cycle");
  ack_err_excl_a: assert property (@(posedge clk) disable iff (srst)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  unmapped_err_a: assert property (@(posedge clk) disable iff (srst)
    ce && req && !known_adr |=> wb_err_o && wb_dat_o == ACK_ERR_DATA)
    else $error("unmapped access not refused");
  mapped_ack_a: assert property (@(posedge clk) disable iff (srst)
    ce && req && known_adr |=> wb_ack_o)
    else $error("mapped access not acknowledged");

  // clock enable low must hold every register
  ce_freeze_a: assert property (@(posedge clk) disable iff (srst)
    !ce |=> $stable(port3_pin_mode_reg) && $stable(port3_irq_enable_pending_reg)
    && $stable(irq_status_reg) && $stable(irq) && $stable(wb_ack_o))
    else $error("state moved while clock enable low");

  // pin modes
  pin3_pullup_a: assert property (@(posedge clk) disable iff (srst)
    ce && pin_mode(port3_pin_mode_reg, 3) == MODE_IN_PU |=> port3_pullup_en[3])
    else $error("pin three pull-up missing");
  pin2_out_a: assert property (@(posedge clk) disable iff (srst)
    ce && port3_pin_mode_reg[5] |=> port3_pin_oe[2] && !port3_analog_sel[2])
    else $error("pin two not driven");
  pin1_out_a: assert property (@(posedge clk) disable iff (srst)
    ce && pin_mode(port3_pin_mode_reg, 1) == MODE_OUT |=> port3_pin_oe[1] && !port3_analog_sel[1])
    else $error("pin one not driven");
  pin1_analog_a: assert property (@(posedge clk) disable iff (srst)
    ce && pin_mode(port3_pin_mode_reg, 1) == MODE_ANALOG |=> port3_analog_sel[1] && !port3_pin_oe[1])
    else $error("pin one analog select wrong");
  pin0_input_a: assert property (@(posedge clk) disable iff (srst)
    ce && pin_mode(port3_pin_mode_reg, 0) == MODE_IN |=> !port3_pin_oe[0] && !port3_pullup_en[0])
    else $error("pin zero not a plain input");
  pin_copy_a: assert property (@(posedge clk) disable iff (srst)
    ce |=> port3_pin_out == $past(port3_pin_out_data))
    else $error("pin output data not copied");

  // edges only on input pins, mapped to their lines
  out_no_edge_a: assert property (@(posedge clk) disable iff (srst)
    !input_mode[2] |-> !fall[2])
    else $error("output pin raised an edge");
  line_six_a: assert property (@(posedge clk) disable iff (srst)
    fall[2] |=> port3_irq_enable_pending_reg[4])
    else $error("edge did not set line six");
  line_five_a: assert property (@(posedge clk) disable iff (srst)
    fall[1] |=> port3_irq_enable_pending_reg[2])
    else $error("edge did not set line five");
  line_four_a: assert property (@(posedge clk) disable iff (srst)
    fall[0] |=> port3_irq_enable_pending_reg[0])
    else $error("edge did not set line four");
  status_set_a: assert property (@(posedge clk) disable iff (srst)
    fall[3] |=> irq_status_reg[3])
    else $error("edge did not set summary status");

  // requests follow enable and pending
  en_write_a: assert property (@(posedge clk) disable iff (srst)
    wr_lo && wb_adr_i == IDX_PORT3_IRQ |=> port3_irq_enable_pending_reg[7] == $past(wb_dat_i[7]))
    else $error("line seven enable not written");
  line_off_a: assert property (@(posedge clk) disable iff (srst)
    ce && !port3_irq_enable_pending_reg[1] |=> !ext_irq_line[0])
    else $error("line four request while disabled");
  irq_level_a: assert property (@(posedge clk) disable iff (srst)
    ce && |(irq_status_reg & irq_enable_reg) |=> irq)
    else $error("interrupt output missing");
  irq_quiet_a: assert property (@(posedge clk) disable iff (srst)
    ce && !(|(irq_status_reg & irq_enable_reg)) |=> !irq)
    else $error("interrupt output without cause");
endmodule : port_cfg

// *** pin_board.sv ***
`timescale 1ns/1ps
module pin_board (
  input wire logic [3:0] oe,
  input wire logic [3:0] drive_out,
  input wire logic [3:0] pull_en,
  input wire logic [3:0] ext_drv,
  input wire logic [3:0] ext_en,
  output logic [3:0] level
);
  // an output pin wins over the board; a released pin rests on its pull-up or low
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      level[i] = oe[i] ? drive_out[i] : (ext_en[i] ? ext_drv[i] : pull_en[i]);
    end
  end
endmodule : pin_board

// *** port2_port3_pin_config_ext_irq_test.sv ***
`timescale 1ns/1ps
module port2_port3_pin_config_ext_irq_test;
  import port_cfg_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [3:0] out_d = 4'h0;
  logic [3:0] drv = 4'hF;
  logic [31:0] rd;
  logic [31:0] rdat;
  logic ack, err, rerr, irq;
  logic [3:0] pin, p_out, oe, pu, an, line;
  logic [6:0] p2_pu;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  port_cfg dut (.clk(clk), .srst(srst), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i({24'h0, wd}), .wb_sel_i(4'hF), .wb_dat_o(rd),
    .wb_ack_o(ack), .wb_err_o(err), .port3_pin_in(pin), .port3_pin_out_data(out_d),
    .port3_pin_out(p_out), .port3_pin_oe(oe), .port3_pullup_en(pu), .port3_analog_sel(an),
    .port2_pullup_en(p2_pu), .ext_irq_line(line), .irq(irq));
  pin_board board (.oe(oe), .drive_out(p_out), .pull_en(pu), .ext_drv(drv), .ext_en(4'hF),
    .level(pin));
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // ack and read data are taken as they stood before the edge updates land
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
    rdat = rd;
    rerr = err;
    cyc <= 1'b0;
  endtask : bus
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    check(rdat, exp);
  endtask : rd_chk
  // the combinational edge detect plus two register stages need two edges; five are waited
  task automatic settle();
    repeat (5) @(negedge clk);
  endtask : settle
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rd_chk(IDX_PORT3_MODE, 32'h0);
    rd_chk(IDX_PORT3_IRQ, 32'h0);
    settle();
    check(p2_pu, 7'h7F);
    check(oe, 4'h0);
    bus(1'b1, IDX_PORT2_PULLUP, 8'hD5);
    settle();
    check(p2_pu, 7'h2A);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, IDX_PORT3_MODE, {4{m[1:0]}});
      settle();
      check(oe, {m[1], m[1], m == 2, m == 2});
      check(pu, (m == 1) ? 4'hF : 4'h0);
      check(an, (m == 3) ? 4'h3 : 4'h0);
    end
    bus(1'b1, IDX_PORT3_MODE, 8'h00);
    bus(1'b1, IDX_IRQ_ENABLE, 8'h0F);
    bus(1'b1, IDX_PORT3_IRQ, 8'hAA);
    bus(1'b1, IDX_IRQ_CLEAR, 8'h0F);
    for (int i = 0; i < 4; i++) begin
      drv[i] <= 1'b0;
      settle();
      check(line, 4'h1 << i);
      check(irq, 1'b1);
      rd_chk(IDX_PORT3_IRQ, 32'hAA | (32'h1 << 2 * i));
      bus(1'b1, IDX_PORT3_IRQ, 8'hFF);
      rd_chk(IDX_PORT3_IRQ, 32'hAA | (32'h1 << 2 * i));
      bus(1'b1, IDX_PORT3_IRQ, 8'hAA);
      rd_chk(IDX_IRQ_STATUS, 32'h1 << i);
      bus(1'b1, IDX_IRQ_CLEAR, 8'h0F);
      drv[i] <= 1'b1;
      settle();
      check({irq, line}, 5'h00);
      rd_chk(IDX_PORT3_IRQ, 32'hAA);
    end
    bus(1'b1, IDX_IRQ_ENABLE, 8'h00);
    drv[0] <= 1'b0;
    settle();
    check({irq, line}, 5'h01);
    bus(1'b1, IDX_IRQ_ENABLE, 8'h01);
    settle();
    check(irq, 1'b1);
    bus(1'b1, IDX_PORT3_IRQ, 8'hAA);
    drv[0] <= 1'b1;
    out_d <= 4'hF;
    bus(1'b1, IDX_PORT3_MODE, 8'hAA);
    out_d <= 4'h0;
    settle();
    rd_chk(IDX_PORT3_IRQ, 32'hAA);
    out_d <= 4'h5;
    settle();
    check(p_out, 4'h5);
    rd_chk(IDX_PIN_STATE, 32'h5);
    bus(1'b0, 8'h00, 8'h00);
    check(rerr, 1'b1);
    check(rdat, 32'h0);
    end_of_test();
  end
endmodule : port2_port3_pin_config_ext_irq_test
